//--- core/holdoff_prescaler.sv
// Divider that turns the system clock into a one-cycle ten-microsecond tick
`default_nettype none
`include "interrupt_output_config_consts.svh"
module holdoff_prescaler #(
    parameter int TICK_CYCLES = `HOLDOFF_TICK_CYCLES
) (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rstn,
    // Control
    input  wire logic restart,
    output logic      tick
);
    localparam int CW = $clog2(TICK_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

    logic [CW-1:0] count_reg;
    wire           at_last = (count_reg == LAST);

    always_ff @(posedge sys_clk)
    begin
        if (!rstn || restart || at_last)
            count_reg <= '0;
        else
            count_reg <= count_reg + CW'(1);
    end

    // Restart realigns the tick so a fresh interval is never short
    assign tick = at_last && !restart;
endmodule // holdoff_prescaler
`default_nettype wire

//--- core/holdoff_timer.sv
// Hold-off interval timer counting prescaler ticks up to a duration latched at start
`default_nettype none
module holdoff_timer #(
    parameter int DUR_W = 8
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rstn,
    // Control
    input  wire logic             start,
    input  wire logic             stop,
    input  wire logic             tick,
    input  wire logic [DUR_W-1:0] duration,
    // Status
    output logic                  active
);
    logic [DUR_W-1:0] count_reg;
    logic [DUR_W-1:0] duration_reg;
    logic             active_reg;

    wire [DUR_W-1:0] count_inc = count_reg + DUR_W'(1);
    wire             expired   = active_reg && tick && (count_inc >= duration_reg);

    always_ff @(posedge sys_clk)
    begin
        if (!rstn || stop)
        begin
            count_reg    <= '0;
            duration_reg <= '0;
            active_reg   <= 1'b0;
        end
        else if (start)
        begin
            // Duration is sampled here, so later nonzero writes affect only later intervals; a zero write raises stop and ends this one
            count_reg    <= '0;
            duration_reg <= duration;
            active_reg   <= (duration != '0);
        end
        else if (expired)
        begin
            count_reg  <= '0;
            active_reg <= 1'b0;
        end
        else if (active_reg && tick)
            count_reg <= count_inc;
    end

    assign active = active_reg;
endmodule // holdoff_timer
`default_nettype wire

//--- core/interrupt_output_config.sv
// Interrupt output stage: line configuration register, hold-off interval and request pin driver
`default_nettype none
`include "interrupt_output_config_consts.svh"
module interrupt_output_config #(
    parameter int SOURCES     = 32,
    parameter int TICK_CYCLES = `HOLDOFF_TICK_CYCLES
) (
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  rstn,
    input  wire logic                  digital_soft_reset,
    // Register access from the serial management port
    input  wire irq_out_pkg::csr_req_t csr_req,
    output logic [31:0]                csr_rdata,
    output logic                       csr_rvalid,
    // Interrupt sources
    input  wire logic [SOURCES-1:0]    source_status,
    input  wire logic [SOURCES-1:0]    source_enable,
    // Request pin, open-drain capable
    output logic                       irq_pin_out,
    output logic                       irq_pin_oe,
    output logic                       holdoff_active_flag
);
    irq_out_pkg::line_cfg_t   cfg_reg;
    irq_out_pkg::pin_state_t  state_reg;
    irq_out_pkg::pin_state_t  state_next;
    logic                     master_reg;
    logic                     clear_reg;
    logic                     pin_out_next;
    logic                     pin_oe_next;

    // Register decode
    wire        wr_hit       = csr_req.wr && (csr_req.addr == `LINE_CFG_OFFSET);
    wire        rd_hit       = csr_req.rd && (csr_req.addr == `LINE_CFG_OFFSET);
    wire [7:0]  wr_interval  = csr_req.wdata[`HOLDOFF_INTERVAL_MSB:`HOLDOFF_INTERVAL_LSB];
    wire        clear_cmd    = wr_hit && csr_req.wdata[`HOLDOFF_CLEAR_BIT];
    wire        zero_wr      = wr_hit && (wr_interval == `HOLDOFF_INTERVAL_RESET);
    wire [7:0]  interval_eff = wr_hit ? wr_interval : cfg_reg.holdoff_interval;

    // Internal request, independent of output enable and hold-off
    wire master_next = |(source_status & source_enable);

    // Hold-off timing
    wire tick;
    wire holdoff_active;
    wire request_on  = (state_reg == irq_out_pkg::PIN_ASSERTED);
    wire request_off = request_on && (!master_reg || !cfg_reg.out_enable);
    wire timer_stop  = zero_wr || digital_soft_reset;
    wire timer_start = !timer_stop && (interval_eff != 8'h00)
                       && (clear_cmd || request_off);

    holdoff_prescaler #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_prescaler (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .restart (timer_start || timer_stop),
        .tick    (tick)
    );

    holdoff_timer #(
        .DUR_W (`HOLDOFF_INTERVAL_MSB - `HOLDOFF_INTERVAL_LSB + 1)
    ) u_timer (
        .sys_clk  (sys_clk),
        .rstn     (rstn),
        .start    (timer_start),
        .stop     (timer_stop),
        .tick     (tick),
        .duration (interval_eff),
        .active   (holdoff_active)
    );

    // Pin sequencing: idle, asserted, held off
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            irq_out_pkg::PIN_IDLE:
                if (holdoff_active)
                    state_next = irq_out_pkg::PIN_HOLDOFF;
                else if (master_reg && cfg_reg.out_enable)
                    state_next = irq_out_pkg::PIN_ASSERTED;
            irq_out_pkg::PIN_ASSERTED:
                if (timer_start)
                    state_next = irq_out_pkg::PIN_HOLDOFF;
                else if (request_off)
                    state_next = irq_out_pkg::PIN_IDLE;
            irq_out_pkg::PIN_HOLDOFF:
                if (timer_stop || !holdoff_active)
                    state_next = irq_out_pkg::PIN_IDLE;
            default:
                state_next = irq_out_pkg::PIN_IDLE;
        endcase
    end

    // Interrupts reach the pin only outside hold-off and with the output enabled
    wire pin_request = (state_next == irq_out_pkg::PIN_ASSERTED)
                       && !timer_start && !holdoff_active;

    // Pin encoding; open-drain ignores polarity and only ever pulls low
    always_comb
    begin
        if (cfg_reg.push_pull)
        begin
            pin_oe_next  = 1'b1;
            pin_out_next = cfg_reg.request_polarity ? pin_request : !pin_request;
        end
        else
        begin
            pin_oe_next  = pin_request;
            pin_out_next = 1'b0;
        end
    end

    // Configuration; polarity and buffer type ignore the soft reset
    // One process owns the whole struct; a write landing in a soft-reset cycle is dropped
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            cfg_reg.holdoff_interval <= `HOLDOFF_INTERVAL_RESET;
            cfg_reg.out_enable       <= `OUT_ENABLE_RESET;
            cfg_reg.request_polarity <= `REQUEST_POLARITY_RESET;
            cfg_reg.push_pull        <= `BUFFER_TYPE_RESET;
            clear_reg                <= 1'b0;
        end
        else if (digital_soft_reset)
        begin
            cfg_reg.holdoff_interval <= `HOLDOFF_INTERVAL_RESET;
            cfg_reg.out_enable       <= `OUT_ENABLE_RESET;
            clear_reg                <= 1'b0;
        end
        else
        begin
            if (wr_hit)
            begin
                cfg_reg.holdoff_interval <= wr_interval;
                cfg_reg.out_enable       <= csr_req.wdata[`OUT_ENABLE_BIT];
                cfg_reg.request_polarity <= csr_req.wdata[`REQUEST_POLARITY_BIT];
                cfg_reg.push_pull        <= csr_req.wdata[`BUFFER_TYPE_BIT];
            end
            clear_reg <= clear_cmd;
        end
    end

    // State, status and pin flops
    always_ff @(posedge sys_clk)
    begin
        if (!rstn || digital_soft_reset)
        begin
            state_reg           <= irq_out_pkg::PIN_IDLE;
            master_reg          <= 1'b0;
            holdoff_active_flag <= 1'b0;
            irq_pin_out         <= 1'b0;
            irq_pin_oe          <= 1'b0;
        end
        else
        begin
            state_reg           <= state_next;
            master_reg          <= master_next;
            holdoff_active_flag <= holdoff_active;
            irq_pin_out         <= pin_out_next;
            irq_pin_oe          <= pin_oe_next;
        end
    end

    // Read data; the self-clearing bit is seen only in the cycle after its write
    wire [31:0] cfg_view = {
        cfg_reg.holdoff_interval, 9'h000, clear_reg, holdoff_active, master_reg,
        3'h0, cfg_reg.out_enable, 3'h0, cfg_reg.request_polarity, 3'h0, cfg_reg.push_pull
    };

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            csr_rdata  <= `UNMAPPED_READ_VALUE;
            csr_rvalid <= 1'b0;
        end
        else
        begin
            csr_rvalid <= csr_req.rd;
            csr_rdata  <= rd_hit ? cfg_view : `UNMAPPED_READ_VALUE;
        end
    end
endmodule // interrupt_output_config
`default_nettype wire

//--- core/interrupt_output_config_consts.svh
// Constants for the interrupt output stage: register offset, field positions, reset values, timing
`ifndef INTERRUPT_OUTPUT_CONFIG_CONSTS_SVH
`define INTERRUPT_OUTPUT_CONFIG_CONSTS_SVH

`define CSR_ADDR_W              10
`define LINE_CFG_OFFSET         10'h054

`define HOLDOFF_INTERVAL_MSB    31
`define HOLDOFF_INTERVAL_LSB    24
`define HOLDOFF_CLEAR_BIT       14
`define HOLDOFF_ACTIVE_BIT      13
`define MASTER_REQUEST_BIT      12
`define OUT_ENABLE_BIT          8
`define REQUEST_POLARITY_BIT    4
`define BUFFER_TYPE_BIT         0

`define HOLDOFF_INTERVAL_RESET  8'h00
`define OUT_ENABLE_RESET        1'b0
`define REQUEST_POLARITY_RESET  1'b0
`define BUFFER_TYPE_RESET       1'b0
`define UNMAPPED_READ_VALUE     32'h0000_0000

`define HOLDOFF_UNIT_NS         10000
`define SYS_CLK_PERIOD_NS       50
`define HOLDOFF_TICK_CYCLES     ((`HOLDOFF_UNIT_NS + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS)

`endif

//--- core/irq_out_pkg.sv
// Types shared by the interrupt output stage
`default_nettype none
package irq_out_pkg;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [9:0]  addr;
        logic [31:0] wdata;
    } csr_req_t;

    typedef struct packed {
        logic [7:0] holdoff_interval;
        logic       out_enable;
        logic       request_polarity;
        logic       push_pull;
    } line_cfg_t;

    typedef enum logic [1:0] {
        PIN_IDLE,
        PIN_ASSERTED,
        PIN_HOLDOFF
    } pin_state_t;

endpackage
`default_nettype wire

//--- verification/host_irq_model.sv
// Host end of the request pin: pull-up and the wired level
`default_nettype none
module host_irq_model (
    // Pin drive from the device
    input  wire logic irq_pin_out,
    input  wire logic irq_pin_oe,
    // Level seen by the host
    output logic      irq_wire
);
    timeunit 1ns;
    timeprecision 1ps;
    // Released pin sits at the pull-up, so sharing stays wired-OR
    assign irq_wire = irq_pin_oe ? irq_pin_out : 1'b1;
endmodule // host_irq_model
`default_nettype wire

//--- verification/irq_out_properties.sv
// Port checks for the interrupt output stage
`default_nettype none
module irq_out_properties #(
    parameter int SOURCES     = 32,
    parameter int TICK_CYCLES = 4
) (
    // Clock and reset
    input wire logic                  sys_clk,
    input wire logic                  rstn,
    input wire logic                  digital_soft_reset,
    // Register access
    input wire irq_out_pkg::csr_req_t csr_req,
    input wire logic [31:0]           csr_rdata,
    input wire logic                  csr_rvalid,
    // Sources and pin
    input wire logic [SOURCES-1:0]    source_status,
    input wire logic [SOURCES-1:0]    source_enable,
    input wire logic                  irq_pin_out,
    input wire logic                  irq_pin_oe,
    input wire logic                  holdoff_active_flag
);
    logic [7:0] iv_reg;
    logic       en_reg;
    logic       pol_reg;
    logic       pp_reg;
    logic [1:0] q_reg;
    wire        wr54 = csr_req.wr && csr_req.addr == 10'h054;
    // Pin flops lag the shadow fields, so pin checks wait for a quiet spell
    wire        calm = q_reg == 2'h3;
    wire        req  = |(source_status & source_enable);
    wire        act  = irq_pin_oe && (pp_reg ? irq_pin_out == pol_reg : !irq_pin_out);
    always_ff @(posedge sys_clk)
    begin
        q_reg <= (!rstn || wr54 || digital_soft_reset) ? 2'h0 : q_reg + {1'b0, !calm};
        if (!rstn || digital_soft_reset)
            {iv_reg, en_reg} <= 9'h0;
        else if (wr54)
            {iv_reg, en_reg} <= {csr_req.wdata[31:24], csr_req.wdata[8]};
        if (!rstn)
            {pol_reg, pp_reg} <= 2'h0;
        else if (wr54 && !digital_soft_reset)
            {pol_reg, pp_reg} <= {csr_req.wdata[4], csr_req.wdata[0]};
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn || digital_soft_reset);
    chk_read_answer: assert property (csr_req.rd |=> csr_rvalid) else $error("no read answer");
    chk_unmapped_zero: assert property (csr_req.rd && csr_req.addr != 10'h054 |=> csr_rdata == 32'h0)
        else $error("unmapped read not zero");
    chk_reserved_zero: assert property (csr_rvalid |-> (csr_rdata & 32'h00ff_8eee) == 32'h0)
        else $error("reserved bits set");
    chk_drain_low:
        assert property (calm && !pp_reg |-> !irq_pin_out) else $error("open-drain drove high");
    chk_enable_off:
        assert property (calm && !en_reg |-> !act) else $error("pin active while disabled");
    chk_holdoff_quiet:
        assert property (calm && holdoff_active_flag |-> !act) else $error("pin active in hold-off");
    chk_holdoff_start:
        assert property (calm && en_reg && iv_reg != 8'h0 && $fell(act) |-> ##[1:3] holdoff_active_flag)
        else $error("no hold-off after release");
    chk_pending_reissue:
        assert property (calm && en_reg && req && $fell(holdoff_active_flag) |-> ##[1:4] act)
        else $error("pending request not reissued");
    cover property ($rose(holdoff_active_flag));
    cover property (calm && pp_reg && act);
    cover property (csr_rvalid && csr_rdata[12]);
endmodule // irq_out_properties
bind interrupt_output_config irq_out_properties #(.SOURCES(SOURCES), .TICK_CYCLES(TICK_CYCLES)) u_chk (
    .sys_clk(sys_clk), .rstn(rstn), .digital_soft_reset(digital_soft_reset), .csr_req(csr_req),
    .csr_rdata(csr_rdata), .csr_rvalid(csr_rvalid), .source_status(source_status),
    .source_enable(source_enable), .irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe),
    .holdoff_active_flag(holdoff_active_flag)
);
`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench for the interrupt output stage
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int T = 4;
    logic                  sys_clk = 1'b0;
    logic                  rstn = 1'b0;
    logic                  digital_soft_reset = 1'b0;
    irq_out_pkg::csr_req_t csr_req = '0;
    logic [31:0]           csr_rdata;
    logic                  csr_rvalid;
    logic [31:0]           source_status = 32'h0;
    logic [31:0]           source_enable = 32'h8;
    logic                  irq_pin_out;
    logic                  irq_pin_oe;
    logic                  holdoff_active_flag;
    logic                  irq_wire;
    int                    n_fail = 0;
    int                    checks = 0;
    interrupt_output_config #(.SOURCES(32), .TICK_CYCLES(T)) u_interrupt_output_config (
        .sys_clk(sys_clk), .rstn(rstn), .digital_soft_reset(digital_soft_reset), .csr_req(csr_req),
        .csr_rdata(csr_rdata), .csr_rvalid(csr_rvalid), .source_status(source_status),
        .source_enable(source_enable), .irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe),
        .holdoff_active_flag(holdoff_active_flag));
    host_irq_model u_host_irq_model (.irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe), .irq_wire(irq_wire));
    initial forever #25 sys_clk = ~sys_clk;
    task automatic end_sim;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Every drive lands 1 ns after a rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("Error %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task automatic near(input int g, input int e);
        checks++;
        if (g < e - 2 || g > e + 2)
        begin
            n_fail++;
            $display("Error %0t: hold-off %0d exp %0d", $time, g, e);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        csr_req = '{1'b1, 1'b0, a, d};
        tick(1);
        csr_req.wr = 1'b0;
        tick(1);
    endtask
    task automatic rd(input logic [9:0] a, input logic [31:0] e);
        csr_req = '{1'b0, 1'b1, a, 32'h0};
        tick(1);
        csr_req.rd = 1'b0;
        cmp({31'h0, csr_rvalid}, 32'h1);
        cmp(csr_rdata, e);
        tick(1);
    endtask
    task automatic pin(input logic e);
        cmp({31'h0, irq_wire}, {31'h0, e});
    endtask
    task automatic hold(input int e);
        int c;
        c = 0;
        while (holdoff_active_flag !== 1'b1 && c < 50)
        begin
            tick(1);
            c++;
        end
        c = 0;
        while (holdoff_active_flag === 1'b1 && c < 2000)
        begin
            tick(1);
            c++;
        end
        near(c, e);
    endtask
    initial
    begin
        #50us;
        n_fail++;
        end_sim();
    end
    initial
    begin
        tick(2);
        rstn = 1'b1;
        rd(10'h054, 32'h0);
        pin(1'b1);
        rd(10'h058, 32'h0);
        wr(10'h058, 32'hffff_ffff);
        source_status = 32'h10;
        rd(10'h054, 32'h0);
        source_enable = 32'h18;
        tick(2);
        rd(10'h054, 32'h0000_1000);
        source_enable = 32'h8;
        wr(10'h054, 32'h0000_0111);
        source_status = 32'h8;
        tick(5);
        pin(1'b1);
        rd(10'h054, 32'h0000_1111);
        wr(10'h054, 32'h0000_0011);
        tick(3);
        pin(1'b0);
        rd(10'h054, 32'h0000_1011);
        wr(10'h054, 32'h0000_0101);
        tick(3);
        pin(1'b0);
        source_status = 32'h0;
        tick(5);
        pin(1'b1);
        source_status = 32'h8;
        wr(10'h054, 32'h0000_0110);
        tick(3);
        pin(1'b0);
        source_status = 32'h0;
        tick(5);
        pin(1'b1);
        wr(10'h054, 32'h0200_0111);
        source_status = 32'h8;
        tick(5);
        pin(1'b1);
        source_status = 32'h0;
        tick(3);
        source_status = 32'h8;
        tick(1);
        rd(10'h054, 32'h0200_3111);
        pin(1'b0);
        tick(10);
        pin(1'b1);
        wr(10'h054, 32'h0500_0111);
        source_status = 32'h0;
        hold(5 * T);
        source_status = 32'h8;
        tick(5);
        source_status = 32'h0;
        tick(12);
        wr(10'h054, 32'h0500_4111);
        hold(5 * T);
        rd(10'h054, 32'h0500_0111);
        source_status = 32'h8;
        tick(5);
        source_status = 32'h0;
        tick(4);
        source_status = 32'h8;
        tick(1);
        pin(1'b0);
        wr(10'h054, 32'h0000_0111);
        tick(3);
        pin(1'b1);
        rd(10'h054, 32'h0000_1111);
        wr(10'h054, 32'h0500_0111);
        source_status = 32'h0;
        digital_soft_reset = 1'b1;
        tick(2);
        digital_soft_reset = 1'b0;
        rd(10'h054, 32'h0000_0011);
        rstn = 1'b0;
        tick(2);
        rstn = 1'b1;
        rd(10'h054, 32'h0);
        end_sim();
    end
endmodule // testbench
`default_nettype wire
